// ---- sac_pkg.sv ----
package sac_pkg;
    localparam logic [7:0] SAC_ADDR_ORDER = 8'h17;
    localparam logic [7:0] SAC_ADDR_TIMING = 8'h39;
    localparam logic [7:0] SAC_ADDR_FECTL = 8'h42;
    localparam logic [7:0] SAC_ADDR_CHGAIN = 8'h55;

    localparam logic [15:0] SAC_RST_ORDER = 16'h0000;
    localparam logic [15:0] SAC_RST_TIMING = 16'h22FC;
    localparam logic [15:0] SAC_RST_FECTL = 16'h1C38;
    localparam logic [15:0] SAC_RST_CHGAIN = 16'h0000;

    // Field positions (low bit) within their registers
    localparam int SAC_ORDER_LSB = 0;
    localparam int SAC_WIDTH_LSB = 11;
    localparam int SAC_DELAY_LSB = 0;
    localparam int SAC_MODE_LSB = 10;
    localparam int SAC_INTG_LSB = 8;
    localparam int SAC_BUFSEL_BIT = 7;
    localparam int SAC_INDEN_BIT = 6;
    localparam int SAC_COMGAIN_LSB = 0;
    localparam int SAC_CH2_LSB = 0;
    localparam int SAC_CH3_LSB = 2;
    localparam int SAC_CH4_LSB = 4;

    localparam logic [5:0] SAC_MODE_RECOMMENDED = 6'h07;

    // Timing units
    localparam int SAC_CLK_PERIOD_NS = 40;
    localparam int SAC_WIDTH_UNIT_NS = 1000;
    localparam int SAC_DELAY_UNIT_PS = 31250;
    localparam int SAC_WIDTH_UNIT_CYC = SAC_WIDTH_UNIT_NS / SAC_CLK_PERIOD_NS;

    typedef struct packed {
        logic [15:0] order;
        logic [15:0] timing;
        logic [15:0] fectl;
        logic [15:0] chgain;
    } sac_cfg_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [15:0] wdata;
    } sac_req_t;

    typedef struct packed {
        logic [3:0][1:0] ch_gain_code;
        logic [3:0][7:0] ch_gain_kohm;
        logic [8:0] int_kohm;
        logic [3:0] buf_gain_tenths;
        logic buffer_mode;
        logic [5:0] frontend_mode;
        logic [4:0] window_width;
        logic [9:0] window_width_cycles;
        logic [10:0] window_delay;
        logic [3:0] polarity_order;
    } sac_out_t;
endpackage

// ---- sac_regs.sv ----
// Notes on behaviour
// - Four-bit order field; bit 0 normal, 1 reversed polarity per pulse.
// - Bit n drives pulse n+1; mapping restarts at bit 0 every four pulses.
// - Window width is five bits in 1 us units, reset code 4.
// - Window delay is eleven bits in 31.25 ns units, reset 0x2FC.
// - Normal integrator: gain 00/01/10 give 400/200/100 kohm.
// - Buffer mode: gain 00 and 01 give unity, 10 gives 0.7.
// - Individual mode: channel 3 gain codes 0..3 give 200/100/50/25 kohm.
// - Individual mode: channel 2 gain uses the same four-code encoding.
// - Per-channel fields only when enable is 1; else common field sets all.
// - Buffer select bit 1 turns integrator into buffer; 0 normal operation.
`timescale 1ns/1ps
`default_nettype none
module sac_regs (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic ce,
    // Register port from the serial control logic
    input wire sac_pkg::sac_req_t req,
    output logic [15:0] rdata,
    output logic rd_valid,
    // Pulse sequencing from the timing core
    input wire logic sample_start,
    input wire logic pulse_strobe,
    output logic pulse_valid,
    output logic pulse_reversed,
    // Decoded configuration
    output sac_pkg::sac_out_t cfg_out
);
    import sac_pkg::*;

    typedef struct packed {
        sac_cfg_t cfg;
        logic [1:0] pulse_idx;
        logic pulse_valid;
        logic pulse_reversed;
        logic [15:0] rdata;
        logic rd_valid;
        sac_out_t out;
    } sac_state_t;

    sac_state_t st;
    sac_state_t next_st;

    function automatic logic [7:0] tia_kohm(input logic [1:0] code);
        logic [7:0] k;
        k = 8'h00;
        unique case (code)
            2'b00: k = 8'hC8;
            2'b01: k = 8'h64;
            2'b10: k = 8'h32;
            2'b11: k = 8'h19;
        endcase
        return k;
    endfunction

    function automatic logic [15:0] read_mux(input sac_cfg_t c,
                                             input logic [7:0] a);
        logic [15:0] d;
        d = 16'h0000;
        // Unmapped addresses read as zero
        case (a)
            SAC_ADDR_ORDER: d = c.order;
            SAC_ADDR_TIMING: d = c.timing;
            SAC_ADDR_FECTL: d = c.fectl;
            SAC_ADDR_CHGAIN: d = c.chgain;
            default: d = 16'h0000;
        endcase
        return d;
    endfunction

    logic ind_en;
    logic [1:0] com_gain;
    logic [1:0] int_gain;
    logic buf_sel;

    assign ind_en = st.cfg.fectl[SAC_INDEN_BIT];
    assign com_gain = st.cfg.fectl[SAC_COMGAIN_LSB +: 2];
    assign int_gain = st.cfg.fectl[SAC_INTG_LSB +: 2];
    assign buf_sel = st.cfg.fectl[SAC_BUFSEL_BIT];

    always_comb begin
        next_st = st;
        next_st.pulse_valid = 1'b0;
        next_st.rd_valid = 1'b0;
        // Register writes; mode and reserved bits stored as written
        if (req.wr) begin
            case (req.addr)
                SAC_ADDR_ORDER: next_st.cfg.order = req.wdata;
                SAC_ADDR_TIMING: next_st.cfg.timing = req.wdata;
                SAC_ADDR_FECTL: next_st.cfg.fectl = req.wdata;
                SAC_ADDR_CHGAIN: next_st.cfg.chgain = req.wdata;
                default: ;
            endcase
        end
        if (req.rd) begin
            next_st.rdata = read_mux(st.cfg, req.addr);
            next_st.rd_valid = 1'b1;
        end
        // Polarity follows the pulse position within the group of four
        if (sample_start) begin
            next_st.pulse_idx = 2'h0;
        end else if (pulse_strobe) begin
            next_st.pulse_valid = 1'b1;
            next_st.pulse_reversed =
                st.cfg.order[SAC_ORDER_LSB + st.pulse_idx];
            next_st.pulse_idx = st.pulse_idx + 2'h1;
        end
        // Decoded outputs lag the register contents by one cycle
        next_st.out.polarity_order = st.cfg.order[SAC_ORDER_LSB +: 4];
        next_st.out.window_width = st.cfg.timing[SAC_WIDTH_LSB +: 5];
        next_st.out.window_width_cycles = 10'(
            st.cfg.timing[SAC_WIDTH_LSB +: 5] * SAC_WIDTH_UNIT_CYC);
        next_st.out.window_delay = st.cfg.timing[SAC_DELAY_LSB +: 11];
        next_st.out.frontend_mode = st.cfg.fectl[SAC_MODE_LSB +: 6];
        next_st.out.buffer_mode = buf_sel;
        // Channel 1 always uses the common field
        next_st.out.ch_gain_code[0] = com_gain;
        if (ind_en) begin
            next_st.out.ch_gain_code[1] =
                st.cfg.chgain[SAC_CH2_LSB +: 2];
            next_st.out.ch_gain_code[2] =
                st.cfg.chgain[SAC_CH3_LSB +: 2];
            next_st.out.ch_gain_code[3] = st.cfg.chgain[SAC_CH4_LSB +: 2];
        end else begin
            next_st.out.ch_gain_code[1] = com_gain;
            next_st.out.ch_gain_code[2] = com_gain;
            next_st.out.ch_gain_code[3] = com_gain;
        end
        for (int i = 0; i < 4; i++) begin
            next_st.out.ch_gain_kohm[i] =
                tia_kohm(next_st.out.ch_gain_code[i]);
        end
        // Code 11 is undefined; it decodes to zero so it is visible
        next_st.out.int_kohm = 9'h000;
        next_st.out.buf_gain_tenths = 4'h0;
        if (buf_sel) begin
            unique case (int_gain)
                2'b00: next_st.out.buf_gain_tenths = 4'hA;
                2'b01: next_st.out.buf_gain_tenths = 4'hA;
                2'b10: next_st.out.buf_gain_tenths = 4'h7;
                2'b11: next_st.out.buf_gain_tenths = 4'h0;
            endcase
        end else begin
            unique case (int_gain)
                2'b00: next_st.out.int_kohm = 9'h190;
                2'b01: next_st.out.int_kohm = 9'h0C8;
                2'b10: next_st.out.int_kohm = 9'h064;
                2'b11: next_st.out.int_kohm = 9'h000;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            st <= '0;
            st.cfg.order <= SAC_RST_ORDER;
            st.cfg.timing <= SAC_RST_TIMING;
            st.cfg.fectl <= SAC_RST_FECTL;
            st.cfg.chgain <= SAC_RST_CHGAIN;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign rdata = st.rdata;
    assign rd_valid = st.rd_valid;
    assign pulse_valid = st.pulse_valid;
    assign pulse_reversed = st.pulse_reversed;
    assign cfg_out = st.out;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    // Polarity order and group position
    chk_order_pick: assert property (
        ce && pulse_strobe && !sample_start |=>
            pulse_valid && pulse_reversed == $past(st.cfg.order[st.pulse_idx]))
        else $error("pulse polarity not taken from order bit");

    chk_order_write: assert property (
        ce && req.wr && req.addr == SAC_ADDR_ORDER |=>
            st.cfg.order == $past(req.wdata))
        else $error("order register write not stored");

    chk_group_wrap: assert property (
        ce && pulse_strobe && !sample_start && st.pulse_idx == 2'h3 |=>
            st.pulse_idx == 2'h0)
        else $error("pulse index did not wrap after four pulses");

    chk_group_restart: assert property (
        ce && sample_start |=> st.pulse_idx == 2'h0 && !pulse_valid)
        else $error("sample start did not restart the group");

    chk_pulse_once: assert property (
        ce && !(pulse_strobe && !sample_start) |=> !pulse_valid)
        else $error("pulse valid without a taken strobe");

    chk_width_reset: assert property (
        $rose(reset_n) |-> st.cfg.timing[15:11] == 5'h04)
        else $error("window width reset code wrong");

    // Decode checks skip the first edge after release: outputs still zero
    chk_width_cycles: assert property (
        $past(reset_n) && $past(ce) |->
            cfg_out.window_width_cycles ==
                10'($past(st.cfg.timing[15:11]) * 25))
        else $error("window width cycles wrong");

    chk_delay_reset: assert property (
        $rose(reset_n) |-> st.cfg.timing[10:0] == 11'h2FC)
        else $error("window delay reset value wrong");

    chk_delay_out: assert property (
        $past(reset_n) && $past(ce) |->
            cfg_out.window_delay == $past(st.cfg.timing[10:0]))
        else $error("window delay not passed out");

    chk_int_normal: assert property (
        $past(reset_n) && $past(ce) && !$past(buf_sel) &&
            $past(int_gain) == 2'b00 |->
            cfg_out.int_kohm == 9'h190 && cfg_out.buf_gain_tenths == 4'h0)
        else $error("normal integrator gain decode wrong");

    chk_int_half: assert property (
        $past(reset_n) && $past(ce) && !$past(buf_sel) &&
            $past(int_gain) == 2'b01 |-> cfg_out.int_kohm == 9'h0C8)
        else $error("integrator code 01 decode wrong");

    chk_int_quarter: assert property (
        $past(reset_n) && $past(ce) && !$past(buf_sel) &&
            $past(int_gain) == 2'b10 |-> cfg_out.int_kohm == 9'h064)
        else $error("integrator code 10 decode wrong");

    chk_buf_gain: assert property (
        $past(reset_n) && $past(ce) && $past(buf_sel) &&
            $past(int_gain) == 2'b10 |->
            cfg_out.buf_gain_tenths == 4'h7 && cfg_out.int_kohm == 9'h000)
        else $error("buffer gain decode wrong");

    chk_buf_unity: assert property (
        $past(reset_n) && $past(ce) && $past(buf_sel) &&
            !$past(int_gain[1]) |->
            cfg_out.buf_gain_tenths == 4'hA && cfg_out.int_kohm == 9'h000)
        else $error("buffer unity gain decode wrong");

    chk_ch3_indiv: assert property (
        $past(reset_n) && $past(ce) && $past(ind_en) |->
            cfg_out.ch_gain_code[2] == $past(st.cfg.chgain[3:2]))
        else $error("channel 3 individual gain wrong");

    chk_ch3_kohm: assert property (
        $past(reset_n) && $past(ce) && $past(ind_en) &&
            $past(st.cfg.chgain[3:2]) == 2'b00 |->
            cfg_out.ch_gain_kohm[2] == 8'hC8)
        else $error("channel 3 individual gain decode wrong");

    chk_ch2_kohm: assert property (
        $past(reset_n) && $past(ce) && $past(ind_en) &&
            $past(st.cfg.chgain[1:0]) == 2'b11 |->
            cfg_out.ch_gain_kohm[1] == 8'h19)
        else $error("channel 2 individual gain decode wrong");

    chk_common_gain: assert property (
        $past(reset_n) && $past(ce) && !$past(ind_en) |->
            cfg_out.ch_gain_code[3] == $past(com_gain) &&
            cfg_out.ch_gain_code[2] == $past(com_gain) &&
            cfg_out.ch_gain_code[1] == $past(com_gain))
        else $error("common gain not applied to all channels");

    chk_ch1_common: assert property (
        $past(reset_n) && $past(ce) |->
            cfg_out.ch_gain_code[0] == $past(com_gain))
        else $error("channel 1 not on the common gain");

    chk_ch4_indiv: assert property (
        $past(reset_n) && $past(ce) && $past(ind_en) |->
            cfg_out.ch_gain_code[3] == $past(st.cfg.chgain[5:4]))
        else $error("channel 4 individual gain wrong");

    // One edge stores the write, the next decodes it
    chk_buffer_bit: assert property (
        ce && req.wr && req.addr == SAC_ADDR_FECTL ##1 ce |=>
            cfg_out.buffer_mode == $past(req.wdata[7], 2))
        else $error("buffer select not applied");

    chk_normal_mode: assert property (
        $past(reset_n) && $past(ce) && !$past(buf_sel) |->
            !cfg_out.buffer_mode && cfg_out.buf_gain_tenths == 4'h0)
        else $error("normal integrator shows buffer gain");

    // Scenarios the bench must reach
    cov_four_pulses: cover property (
        (ce && pulse_strobe && !sample_start) [*4] ##1 st.pulse_idx == 2'h0);
    cov_buffer_mode: cover property (cfg_out.buffer_mode &&
        cfg_out.buf_gain_tenths == 4'h7);
    cov_indiv_gain: cover property ($past(ind_en) &&
        cfg_out.ch_gain_code[2] != cfg_out.ch_gain_code[0]);
    cov_read_back: cover property (rd_valid && rdata != 16'h0000);
    cov_frozen_write: cover property (!ce && req.wr);
endmodule
`default_nettype wire

// ---- sac_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
    import sac_pkg::*;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic ce = 1'b1;
    sac_req_t req = '0;
    logic sample_start = 1'b0;
    logic pulse_strobe = 1'b0;
    logic [15:0] rdata;
    logic rd_valid;
    logic pulse_valid;
    logic pulse_reversed;
    sac_out_t cfg_out;
    sac_cfg_t sh;
    logic [7:0] a;
    logic [15:0] v;
    logic [7:0] addrs [4];
    int error_cnt = 0;
    int checks_done = 0;

    sac_regs i_sac_regs (.mclk(mclk), .reset_n(reset_n), .ce(ce), .req(req),
        .rdata(rdata), .rd_valid(rd_valid), .sample_start(sample_start),
        .pulse_strobe(pulse_strobe), .pulse_valid(pulse_valid),
        .pulse_reversed(pulse_reversed), .cfg_out(cfg_out));

    initial begin
        forever #20 mclk = ~mclk;
    end

    task automatic end_sim();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic ok, input string m);
        checks_done++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask

    // Inputs always move 1 ns after the edge, never on it
    task automatic step();
        @(posedge mclk);
        #1;
    endtask

    function automatic logic [15:0] shv(input logic [7:0] ad);
        case (ad)
            SAC_ADDR_ORDER: return sh.order;
            SAC_ADDR_TIMING: return sh.timing;
            SAC_ADDR_FECTL: return sh.fectl;
            SAC_ADDR_CHGAIN: return sh.chgain;
            default: return 16'h0000;
        endcase
    endfunction

    task automatic wr(input logic [7:0] ad, input logic [15:0] d);
        step();
        req.wr = 1'b1;
        req.addr = ad;
        req.wdata = d;
        if (ce) begin
            case (ad)
                SAC_ADDR_ORDER: sh.order = d;
                SAC_ADDR_TIMING: sh.timing = d;
                SAC_ADDR_FECTL: sh.fectl = d;
                SAC_ADDR_CHGAIN: sh.chgain = d;
                default: ;
            endcase
        end
        step();
        req.wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] ad, input logic [15:0] e);
        step();
        req.rd = 1'b1;
        req.addr = ad;
        step();
        req.rd = 1'b0;
        chk(rd_valid === 1'b1 && rdata === e, "read data");
    endtask

    function automatic sac_out_t exp_out(input sac_cfg_t c);
        sac_out_t o;
        logic [1:0] g;
        logic b;
        o = '0;
        b = c.fectl[7];
        g = c.fectl[9:8];
        o.ch_gain_code[0] = c.fectl[1:0];
        for (int i = 1; i < 4; i++) begin
            o.ch_gain_code[i] = c.fectl[6] ? c.chgain[2*i-2 +: 2]
                                           : c.fectl[1:0];
        end
        for (int i = 0; i < 4; i++) begin
            o.ch_gain_kohm[i] = 8'(200 >> o.ch_gain_code[i]);
        end
        if (!b && g != 2'h3) o.int_kohm = 9'(400 >> g);
        if (b && g != 2'h3) o.buf_gain_tenths = (g == 2'h2) ? 4'h7 : 4'hA;
        o.buffer_mode = b;
        o.frontend_mode = c.fectl[15:10];
        o.window_width = c.timing[15:11];
        o.window_width_cycles = 10'(c.timing[15:11] * 25);
        o.window_delay = c.timing[10:0];
        o.polarity_order = c.order[3:0];
        return o;
    endfunction

    // Decoded outputs trail the register by one edge
    task automatic cfgchk();
        step();
        chk(cfg_out === exp_out(sh), "decoded config");
    endtask

    initial begin
        void'($urandom(79963));
        addrs = '{SAC_ADDR_ORDER, SAC_ADDR_TIMING,
                  SAC_ADDR_FECTL, SAC_ADDR_CHGAIN};
        sh = '{16'h0000, {5'h04, 11'h2FC}, SAC_RST_FECTL, 16'h0000};
        repeat (16) @(posedge mclk);
        #1;
        reset_n = 1'b1;
        cfgchk();
        foreach (addrs[i]) rd(addrs[i], shv(addrs[i]));
        wr(8'h20, 16'hFFFF);
        rd(8'h20, 16'h0000);
        wr(SAC_ADDR_CHGAIN, 16'h00E4);
        for (int m = 0; m < 16; m++) begin
            wr(SAC_ADDR_FECTL, {SAC_MODE_RECOMMENDED, 4'(m), 6'h35});
            cfgchk();
        end
        for (int n = 0; n < 40; n++) begin
            a = addrs[$urandom_range(3)];
            v = 16'($urandom);
            if (a == SAC_ADDR_ORDER) v[15:4] = 12'h000;
            if (a == SAC_ADDR_FECTL) v[15:10] = SAC_MODE_RECOMMENDED;
            wr(a, v);
            rd(a, v);
            cfgchk();
        end
        // Frozen clock enable must swallow the write
        ce = 1'b0;
        wr(SAC_ADDR_TIMING, 16'h0801);
        ce = 1'b1;
        rd(SAC_ADDR_TIMING, shv(SAC_ADDR_TIMING));
        for (int n = 0; n < 4; n++) begin
            wr(SAC_ADDR_ORDER, {12'h000, (n == 0) ? 4'h5 : 4'($urandom)});
            step();
            sample_start = 1'b1;
            pulse_strobe = 1'b1;
            step();
            chk(pulse_valid === 1'b0, "strobe taken during restart");
            sample_start = 1'b0;
            for (int k = 0; k < 6; k++) begin
                step();
                chk(pulse_valid === 1'b1 &&
                    pulse_reversed === sh.order[k % 4], "polarity");
            end
            pulse_strobe = 1'b0;
            step();
            chk(pulse_valid === 1'b0, "pulse valid width");
        end
        reset_n = 1'b0;
        step();
        reset_n = 1'b1;
        sh = '{16'h0000, {5'h04, 11'h2FC}, SAC_RST_FECTL, 16'h0000};
        cfgchk();
        rd(SAC_ADDR_TIMING, 16'h22FC);
        end_sim();
    end

    initial begin
        #400000;
        $display("MISMATCH %0t timeout", $time);
        error_cnt++;
        end_sim();
    end
endmodule
`default_nettype wire
